// *** logic/lsb_channel.sv ***
// one sink channel: blink counter and current level decode
`timescale 1ns/100ps
module lsb_channel
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  lsb_ch_if.chan ch
);
  logic [7:0] phase;
  logic on;
  logic [7:0] level;
  logic [7:0] last_cnt;
  logic [8:0] on_len;
  logic [7:0] fs;
  logic [12:0] prod;

  // period is (code+1) * 16 root ticks
  assign last_cnt = {ch.cfg.period, 4'hF}; // [R03]
  // on-time is (duty+1)/16 of the period; all ones covers it fully
  assign on_len = 9'({1'b0, ch.cfg.duty} + 5'h01) * 9'(ch.cfg.period + 5'h01);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      phase <= 8'h00;
    else if (!ch.cfg.en)
      phase <= 8'h00;
    else if (ch.tick)
    begin
      if (phase >= last_cnt) // [R06]
        phase <= 8'h00;
      else
        phase <= phase + 8'h01;
    end
  end

  // on-window is duty+1 steps of period/16 from start of each period
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      on <= 1'b0;
    else
      on <= ch.cfg.en && ({1'b0, phase} < on_len); // [R04] [R05] [R06]
  end

  always_comb
  begin
    case (ch.cfg.range_sel) // [R02]
      lsb_pkg::RANGE_3M2: fs = lsb_pkg::FS_3M2;
      lsb_pkg::RANGE_6M4: fs = lsb_pkg::FS_6M4;
      lsb_pkg::RANGE_12M8: fs = lsb_pkg::FS_12M8;
      default: fs = 8'h00;
    endcase
  end

  // equal steps: (code+1)/32 of full scale, in 0.1 mA units
  assign prod = 13'({3'h0, ch.cfg.brt} + 8'h01) * 13'(fs); // [R01]

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      level <= 8'h00;
    else
      level <= on ? prod[12:5] : 8'h00; // [R01]
  end

  assign ch.on = on;
  assign ch.level = level;
  assign ch.phase = phase;
endmodule : lsb_channel

// *** logic/lsb_top.sv ***
// apb register file, root tick divider and two sink channels
//
// Summary of operation
// (R01) 5-bit brightness code sets sink current in equal steps to full scale.
// (R02) range 01/10/11 select 3.2/6.4/12.8 mA full scale.
// (R03) blink period is (code+1) times 16 root ticks, 16 to 256.
// (R04) on-time is (duty+1) sixteenths of the period.
// (R05) duty all ones keeps the sink on the whole period.
// (R06) each channel counts root ticks; on from period start for on-time.
`timescale 1ns/100ps
module lsb_top
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [1:0] sink_on_out,
  output logic [7:0] sink0_level_out,
  output logic [7:0] sink1_level_out,
  output logic root_tick_out
);
  logic [31:0] ctrl [lsb_pkg::NUM_CH];
  logic [lsb_pkg::DIV_W-1:0] div_max;
  logic [lsb_pkg::DIV_W-1:0] div_cnt;
  logic tick;
  logic wr_en;
  logic rd_en;
  logic [1:0] on_v;
  logic [7:0] lvl [lsb_pkg::NUM_CH];
  logic [7:0] ph [lsb_pkg::NUM_CH];

  function automatic logic ofs_is_ctrl(input logic [11:0] a);
    ofs_is_ctrl = (a == lsb_pkg::OFS_CH0_CTRL) ||
      (a == lsb_pkg::OFS_CH1_CTRL);
  endfunction : ofs_is_ctrl

  function automatic logic ofs_valid(input logic [11:0] a);
    ofs_valid = ofs_is_ctrl(a) || (a == lsb_pkg::OFS_STATUS) ||
      (a == lsb_pkg::OFS_ROOTDIV);
  endfunction : ofs_valid

  // zero-wait slave; unmapped addresses answer with pslverr
  assign pready_out = 1'b1;
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pslverr_out <= 1'b0;
    else
      pslverr_out <= psel_in && !penable_in && !ofs_valid(paddr_in);
  end

  generate
    for (genvar i = 0; i < lsb_pkg::NUM_CH; i++)
    begin : g_ch
      lsb_ch_if chif ();
      always_ff @(posedge clk_in or negedge rst_b_in)
      begin
        if (!rst_b_in)
          ctrl[i] <= lsb_pkg::CTRL_RST;
        else if (wr_en && paddr_in == 12'(4 * i))
          ctrl[i] <= pwdata_in;
      end
      assign chif.cfg.en = ctrl[i][lsb_pkg::F_EN_BIT];
      assign chif.cfg.brt = ctrl[i][lsb_pkg::F_BRT_LSB +: lsb_pkg::BRT_W];
      assign chif.cfg.range_sel =
        ctrl[i][lsb_pkg::F_RANGE_LSB +: lsb_pkg::RANGE_W];
      assign chif.cfg.period =
        ctrl[i][lsb_pkg::F_PER_LSB +: lsb_pkg::CODE_W];
      assign chif.cfg.duty =
        ctrl[i][lsb_pkg::F_DUTY_LSB +: lsb_pkg::CODE_W];
      assign chif.tick = tick; // [R06]
      assign on_v[i] = chif.on;
      assign lvl[i] = chif.level;
      assign ph[i] = chif.phase;
      lsb_channel u_ch
      (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ch(chif.chan)
      );
    end
  endgenerate

  // root divider is writable so simulation can shorten the 32 Hz tick
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      div_max <= lsb_pkg::DIV_W'(lsb_pkg::ROOT_DIV - 1);
    else if (wr_en && paddr_in == lsb_pkg::OFS_ROOTDIV)
      div_max <= pwdata_in[lsb_pkg::DIV_W-1:0];
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      div_cnt <= '0;
    else if (div_cnt >= div_max)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      tick <= 1'b0;
    else
      tick <= (div_cnt >= div_max); // [R03]
  end

  // read data registered in setup phase, stable through access
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      prdata_out <= 32'h0000_0000;
    else if (rd_en)
    begin
      if (paddr_in == lsb_pkg::OFS_CH0_CTRL)
        prdata_out <= ctrl[0];
      else if (paddr_in == lsb_pkg::OFS_CH1_CTRL)
        prdata_out <= ctrl[1];
      else if (paddr_in == lsb_pkg::OFS_STATUS)
        prdata_out <= {14'h0000, on_v, ph[1], ph[0]};
      else if (paddr_in == lsb_pkg::OFS_ROOTDIV)
        prdata_out <= {9'h000, div_max};
      else
        prdata_out <= 32'h0000_0000;
    end
  end

  assign sink_on_out = on_v;
  assign sink0_level_out = lvl[0];
  assign sink1_level_out = lvl[1];
  assign root_tick_out = tick;
endmodule : lsb_top

// *** shared/lsb_ch_if.sv ***
// interface between the control top and one blink channel
`timescale 1ns/100ps
interface lsb_ch_if;
  lsb_pkg::lsb_ch_cfg_s cfg;
  logic tick;
  logic on;
  logic [7:0] level;
  logic [7:0] phase;
  modport ctrl (output cfg, output tick, input on, input level, input phase);
  modport chan (input cfg, input tick, output on, output level, output phase);
endinterface : lsb_ch_if

// *** shared/lsb_pkg.sv ***
// package of constants and types for the led sink blink control block
package lsb_pkg;
  localparam int NUM_CH = 2;
  localparam int BRT_W = 5;
  localparam int RANGE_W = 2;
  localparam int CODE_W = 4;
  // root clock: 32 Hz nominal, derived from the 200 MHz system clock
  localparam longint CLK_HZ = 200000000;
  localparam longint ROOT_HZ = 32;
  localparam int ROOT_DIV = int'(CLK_HZ / ROOT_HZ);
  localparam int DIV_W = 23;
  // range select encodings, full scale in units of 0.1 mA
  localparam logic [1:0] RANGE_OFF = 2'h0;
  localparam logic [1:0] RANGE_3M2 = 2'h1;
  localparam logic [1:0] RANGE_6M4 = 2'h2;
  localparam logic [1:0] RANGE_12M8 = 2'h3;
  localparam logic [7:0] FS_3M2 = 8'h20;
  localparam logic [7:0] FS_6M4 = 8'h40;
  localparam logic [7:0] FS_12M8 = 8'h80;
  localparam int PERIOD_STEP = 16;
  // register byte offsets
  localparam logic [11:0] OFS_CH0_CTRL = 12'h000;
  localparam logic [11:0] OFS_CH1_CTRL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_ROOTDIV = 12'h00C;
  // control word fields
  localparam int F_BRT_LSB = 0;
  localparam int F_RANGE_LSB = 8;
  localparam int F_PER_LSB = 16;
  localparam int F_DUTY_LSB = 24;
  localparam int F_EN_BIT = 31;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef struct packed {
    logic en;
    logic [BRT_W-1:0] brt;
    logic [RANGE_W-1:0] range_sel;
    logic [CODE_W-1:0] period;
    logic [CODE_W-1:0] duty;
  } lsb_ch_cfg_s;
endpackage : lsb_pkg

// *** sim/lsb_checker.sv ***
// checker for the sink blink top, channel 0 watched
`timescale 1ns/100ps
module lsb_checker
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [1:0] sink_on_out,
  input wire logic [7:0] sink0_level_out,
  input wire logic root_tick_out
);
  logic [31:0] cfg;
  logic [11:0] cnt;
  logic [8:0] ont;
  logic [8:0] oft;
  wire wr = psel_in && penable_in && pwrite_in;
  wire [8:0] d1 = {5'h00, cfg[27:24]} + 9'h001;
  wire [8:0] p1 = {5'h00, cfg[19:16]} + 9'h001;
  wire [7:0] lv = cfg[9:8] == 2'h0 ? 8'h00 :
    ({3'h0, cfg[4:0]} + 8'h01) << (cfg[9:8] - 2'h1);
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) cfg <= 32'h0000_0000;
    else if (wr && paddr_in == 12'h000) cfg <= pwdata_in;
  // quiet span outlasts any blink interval at a short divider
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) cnt <= 12'h000;
    else if (wr) cnt <= 12'h000;
    else if (cnt != 12'hFFF) cnt <= cnt + 12'h001;
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) ont <= 9'h000;
    else ont <= sink_on_out[0] ? ont + {8'h00, root_tick_out} : 9'h000;
  always_ff @(posedge clk_in or negedge rst_b_in)
    if (!rst_b_in) oft <= 9'h000;
    else oft <= sink_on_out[0] ? 9'h000 : oft + {8'h00, root_tick_out};
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence s_quiet;
    cnt == 12'hFFF && cfg[31];
  endsequence
  AST_TICK: assert property (root_tick_out |=> !root_tick_out)
    else $error("tick too long");
  AST_OFF: assert property (cnt == 12'hFFF && !cfg[31] |->
    !sink_on_out[0] && sink0_level_out == 8'h00) else $error("off bad");
  AST_LEVEL: assert property (s_quiet ##0
    $past(sink_on_out[0]) && sink_on_out[0] |-> sink0_level_out == lv)
    else $error("level bad");
  AST_FULL: assert property (s_quiet ##0 cfg[27:24] == 4'hF |->
    sink_on_out[0]) else $error("full duty dropped");
  AST_ONTIME: assert property (s_quiet ##0 $fell(sink_on_out[0]) |->
    ont == d1 * p1) else $error("on time bad");
  AST_OFFTIME: assert property (s_quiet ##0 $rose(sink_on_out[0]) |->
    oft == (9'h010 - d1) * p1) else $error("off time bad");
endmodule : lsb_checker
bind lsb_top lsb_checker chk_u (.clk_in, .rst_b_in, .psel_in, .penable_in,
  .pwrite_in, .paddr_in, .pwdata_in, .sink_on_out, .sink0_level_out,
  .root_tick_out);

// *** sim/tb_top.sv ***
// self-checking bench for the sink blink top
`timescale 1ns/100ps
module tb_top;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [1:0] sink_on_out;
  logic [7:0] sink0_level_out;
  logic [7:0] sink1_level_out;
  logic root_tick_out;
  int exp_lvl;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int samples_checked = 0;
  lsb_top dut_u (.clk_in, .rst_b_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
    .sink_on_out, .sink0_level_out, .sink1_level_out, .root_tick_out);
  initial forever #2.5 clk_in = ~clk_in;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic summarize();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] wd);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  function automatic logic [31:0] ctl(input logic [3:0] p,
    input logic [3:0] d, input logic [1:0] r, input logic [4:0] b);
    return {1'b1, 3'h0, d, 4'h0, p, 6'h00, r, 3'h0, b};
  endfunction : ctl
  // channel 1 timing: ticks counted in on and off spans
  task automatic blink(input logic [3:0] p, input logic [3:0] d);
    int n_on;
    int n_off;
    n_on = 0;
    n_off = 0;
    apb(1'b1, 12'h004, ctl(p, d, 2'h1, 5'h1F));
    // first rise after a write may come mid-period or without a wrap tick
    repeat (2) @(negedge clk_in);
    while (sink_on_out[1] !== 1'b1) @(negedge clk_in);
    while (sink_on_out[1] !== 1'b0) @(negedge clk_in);
    while (sink_on_out[1] !== 1'b1) @(negedge clk_in);
    while (sink_on_out[1] === 1'b1)
    begin
      n_on += root_tick_out;
      @(negedge clk_in);
    end
    cmp(sink1_level_out, 8'h20);
    while (sink_on_out[1] === 1'b0)
    begin
      n_off += root_tick_out;
      @(negedge clk_in);
    end
    cmp(sink1_level_out, 8'h00);
    cmp(n_on, (d + 1) * (p + 1));
    cmp(n_off, (15 - d) * (p + 1));
    $display("blink test done");
  endtask : blink
  initial
  begin
    #400000;
    num_errors++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    apb(1'b0, 12'h000, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    apb(1'b0, 12'h010, 32'h0000_0000);
    cmp(rd, 32'h0000_0000);
    cmp({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    cmp(rd, 32'h005F_5E0F);
    cmp({31'h0, err}, 32'h0000_0000);
    // short divider (tick every 4 cycles) keeps blink spans under a thousand cycles
    apb(1'b1, 12'h00C, 32'h0000_0003);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    cmp(rd, 32'h0000_0003);
    $display("register test done");
    for (int r = 0; r < 4; r++)
      for (int b = 0; b < 32; b += 31)
      begin
        apb(1'b1, 12'h000, ctl(4'h0, 4'hF, r[1:0], b[4:0]));
        repeat (8) @(negedge clk_in);
        exp_lvl = (r == 0) ? 0 : ((b + 1) * 32 << (r - 1)) >> 5;
        cmp(sink0_level_out, exp_lvl);
        cmp(sink_on_out[0], 1'b1);
      end
    $display("level test done");
    blink(4'h0, 4'h0);
    blink(4'h1, 4'h2);
    blink(4'hF, 4'h0);
    blink(4'h0, 4'hE);
    apb(1'b1, 12'h000, ctl(4'h1, 4'h2, 2'h3, 5'h1F));
    repeat (6000) @(posedge clk_in);
    // long quiet spans let the checker see full duty and a disabled channel
    apb(1'b1, 12'h000, ctl(4'h0, 4'hF, 2'h2, 5'h05));
    repeat (4200) @(posedge clk_in);
    @(negedge clk_in);
    cmp(sink0_level_out, 8'h0C);
    cmp(sink_on_out[0], 1'b1);
    apb(1'b1, 12'h000, ctl(4'h1, 4'h2, 2'h3, 5'h1F) & 32'h7FFF_FFFF);
    repeat (4200) @(posedge clk_in);
    @(negedge clk_in);
    cmp(sink_on_out[0], 1'b0);
    cmp(sink0_level_out, 8'h00);
    $display("idle test done");
    summarize();
  end
endmodule : tb_top
